// ### logic/sfs_map.vh
// Constants for the supply fault supervisor: flag positions, timing, test states.
// Assumes a 40 MHz ref_clk; included by the supervisor module only.
`ifndef SFS_MAP_VH
`define SFS_MAP_VH

// ==========================================
// Timing
`define SFS_CLK_MHZ 40
`define SFS_DC2L_QUAL_US 60
// 60 us at 40 MHz, written out at the filter's width
`define SFS_DC2L_QUAL_CYC 16'h0960
`define SFS_DC2U_QUAL_CYC 16'h0010
`define SFS_QUAL_W 16
`define SFS_TMR_TEST_CYC 8'h20
`define SFS_OSC_WIN 8'h40
`define SFS_OSC_MIN 8'h18
`define SFS_OSC_MAX 8'h28
`define SFS_PHASE_CYC 8'h08
`define SFS_SETTLE_CYC 8'h10

// ==========================================
// Detector inputs (det_in bit positions)
`define SFS_NDET 23
`define SFS_D_BAT 0
`define SFS_D_DC1U 1
`define SFS_D_DC1L 2
`define SFS_D_DC1OC 3
`define SFS_D_DC2U 4
`define SFS_D_DC2L 5
`define SFS_D_DC2OC 6
`define SFS_D_SWL 7
`define SFS_D_L1U 8
`define SFS_D_L1L1 9
`define SFS_D_L1L2 10
`define SFS_D_L2U 11
`define SFS_D_L2L 12
`define SFS_D_ADU 13
`define SFS_D_ADL 14
`define SFS_D_T1U 15
`define SFS_D_T1L 16
`define SFS_D_T2U 17
`define SFS_D_T2L 18
`define SFS_D_WRN1 19
`define SFS_D_WRN2 20
`define SFS_D_TSD 21
`define SFS_D_OSC 22
`define SFS_VOLT_LO 0
`define SFS_VOLT_HI 18
`define SFS_VOLT_W 19
`define SFS_DC2U_BIT 4
`define SFS_DC2L_BIT 5

// ==========================================
// Flag registers: 2-bit register address and widths
`define SFS_A_FLAG0 2'h0
`define SFS_A_FLAG1 2'h1
`define SFS_A_FLAG2 2'h2
`define SFS_A_STAT 2'h3
`define SFS_DIAG_W 5
`define SFS_G_DIAG 23
`define SFS_DG_DET 0
`define SFS_DG_TMR 1
`define SFS_DG_OSC 2
`define SFS_DG_TSD 3
`define SFS_DG_DUMMY 4
`define SFS_NFLAG 28

// ==========================================
// Self-test states (one-hot)
`define SFS_ST_W 6
`define SFS_S_DET 6'h01
`define SFS_S_TMR 6'h02
`define SFS_S_OSC 6'h04
`define SFS_S_TSD 6'h08
`define SFS_S_RUN 6'h10
`define SFS_S_HALT 6'h20

`endif

// ### logic/sfs_supervisor.v
// Supply fault supervisor: detector reactions, self-test, fault flags, interrupt pin.
// Assumes comparator outputs arrive asynchronously and are synchronised here;
// register port is a plain same-clock strobe port driven by a host bridge.
//
// Behaviour
// [RULE1] Voltage reactions off until self-test done
// [RULE2] Hysteretic high/low detection pulls interrupt low
// [RULE3] Core buck detectors qualified, 60 us low
// [RULE4] Optional reset on qualified core-buck low
// [RULE5] Battery low: interrupt, stop all regulators
// [RULE6] Buck1 over: stop both bucks, interrupt
// [RULE7] Buck1 under: buck1 interval mode, interrupt
// [RULE8] Buck1 overcurrent: buck1 interval mode, interrupt
// [RULE9] Main LDO level1 low: suspend and interrupt
// [RULE10] Main LDO level2 low: reset
// [RULE11] Core buck over: stop core buck, interrupt
// [RULE12] Core buck low: protect, interval, interrupt
// [RULE13] Core overcurrent: core buck interval, interrupt
// [RULE14] Trackers, LDOs, switched out: interrupt only
// [RULE15] Warning temperature: interrupt, keep regulating
// [RULE16] Shutdown temperature: stop everything, interrupt
// [RULE17] Self-test during initial reset
// [RULE18] Detector test by comparator test inputs
// [RULE19] Logic check fail blocks normal operation
// [RULE20] Oscillator fail: switch oscillator, interrupt
// [RULE21] Thermal shutdown path checked, interrupt
// [RULE22] Pre-start self-test error holds interrupt low
// [RULE23] Group summary clears when group empty
// [RULE24] Flags survive external reset output
// [RULE25] Interrupt low while unmasked flag set
`timescale 1ns/1ps
`include "sfs_map.vh"

module sfs_supervisor (
  input wire ref_clk,
  input wire srst,
  input wire clk_en,
  input wire [`SFS_NDET-1:0] det_in,
  input wire osc_tick,
  input wire core_low_reset_en,
  input wire [1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg det_test_en,
  output reg det_test_level,
  output reg fault_irq_n,
  output reg suspend_out,
  output reg system_reset_n,
  output reg regs_stop,
  output reg buck1_stop,
  output reg buck1_interval,
  output reg core_buck_stop,
  output reg core_buck_interval,
  output reg protect_mode,
  output reg osc_select,
  output reg diag_done
);

  // ==========================================
  // Input synchronisers
  reg [`SFS_NDET-1:0] det_s1;
  reg [`SFS_NDET-1:0] det_s2;
  reg tick_s1;
  reg tick_s2;
  reg tick_s3;

  always @(posedge ref_clk) begin
    if (srst) begin
      det_s1 <= {`SFS_NDET{1'b0}};
      det_s2 <= {`SFS_NDET{1'b0}};
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end else if (clk_en) begin
      det_s1 <= det_in;
      det_s2 <= det_s1;
      tick_s1 <= osc_tick;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end

  wire tick_rise = tick_s2 & ~tick_s3;

  // ==========================================
  // Core buck qualification filters
  // No release level on these comparators, so a glitch filter stands in.
  wire [1:0] core_qual;

  genvar gq;
  generate
    for (gq = 0; gq < 2; gq = gq + 1) begin : g_qual
      // Bit 0 is the over detector, bit 1 the under one
      wire [`SFS_QUAL_W-1:0] lim = (gq == 0) ? `SFS_DC2U_QUAL_CYC : `SFS_DC2L_QUAL_CYC;
      reg [`SFS_QUAL_W-1:0] cnt;
      reg hit;
      always @(posedge ref_clk) begin
        if (srst) begin
          cnt <= {`SFS_QUAL_W{1'b0}};
          hit <= 1'b0;
        end else if (clk_en) begin
          if (!det_s2[`SFS_DC2U_BIT + gq]) begin
            cnt <= {`SFS_QUAL_W{1'b0}};
            hit <= 1'b0;
          end else if (cnt < lim) begin
            cnt <= cnt + {{(`SFS_QUAL_W-1){1'b0}}, 1'b1};
          end else begin
            hit <= 1'b1; // [RULE3]
          end
        end
      end
      // Each filter owns its own state; only the result is shared
      assign core_qual[gq] = hit;
    end
  endgenerate

  // ==========================================
  // Detector test decode
  // True when every voltage comparator reads the given test level
  function sfs_all_at;
    input [`SFS_VOLT_W-1:0] v;
    input lvl;
    begin
      sfs_all_at = (v == {`SFS_VOLT_W{lvl}});
    end
  endfunction

  // ==========================================
  // Self-test sequencer
  reg [`SFS_ST_W-1:0] st;
  reg [7:0] st_cnt;
  reg [7:0] osc_cnt;
  reg osc_bad;
  reg osc_fail_q;
  reg logic_ok;
  reg [`SFS_DIAG_W-1:0] diag_evt;

  always @(posedge ref_clk) begin
    if (srst) begin
      st <= `SFS_S_DET;
      st_cnt <= 8'h00;
      osc_cnt <= 8'h00;
      osc_bad <= 1'b0;
      osc_fail_q <= 1'b0;
      logic_ok <= 1'b0;
      det_test_en <= 1'b1;
      det_test_level <= 1'b0;
      diag_evt <= {`SFS_DIAG_W{1'b0}};
      diag_done <= 1'b0;
    end else if (clk_en) begin
      diag_evt <= {`SFS_DIAG_W{1'b0}};
      st_cnt <= st_cnt + 8'h01;
      case (st)
        `SFS_S_DET: begin
          // Drive test level low, then high; comparators must follow.
          if (st_cnt == `SFS_PHASE_CYC) begin
            if (!sfs_all_at(det_s2[`SFS_VOLT_HI:`SFS_VOLT_LO], 1'b0))
              diag_evt[`SFS_DG_DET] <= 1'b1; // [RULE18]
            det_test_level <= 1'b1;
          end else if (st_cnt == `SFS_SETTLE_CYC) begin
            if (!sfs_all_at(det_s2[`SFS_VOLT_HI:`SFS_VOLT_LO], 1'b1))
              diag_evt[`SFS_DG_DET] <= 1'b1; // [RULE18]
            det_test_level <= 1'b0;
            det_test_en <= 1'b0;
            st_cnt <= 8'h00;
            st <= `SFS_S_TMR;
          end
        end
        `SFS_S_TMR: begin
          // Timer counts a known span; a stuck counter never reaches it.
          if (st_cnt == `SFS_TMR_TEST_CYC) begin
            logic_ok <= 1'b1;
            st_cnt <= 8'h00;
            st <= `SFS_S_OSC;
          end else if (st_cnt > `SFS_TMR_TEST_CYC) begin
            st <= `SFS_S_HALT; // [RULE19]
          end
        end
        `SFS_S_OSC: begin
          if (st_cnt == `SFS_OSC_WIN) begin
            if (osc_cnt < `SFS_OSC_MIN || osc_cnt > `SFS_OSC_MAX)
              osc_bad <= 1'b1;
            st_cnt <= 8'h00;
            osc_cnt <= 8'h00;
            st <= `SFS_S_TSD;
          end else if (tick_rise) begin
            osc_cnt <= osc_cnt + 8'h01;
          end
        end
        `SFS_S_TSD: begin
          // Test level drives the thermal comparator too. The drive is dropped
          // well before the run state, so no test level leaks into reactions.
          if (st_cnt < `SFS_PHASE_CYC) begin
            det_test_en <= 1'b1;
            det_test_level <= 1'b1;
          end else if (st_cnt == `SFS_PHASE_CYC) begin
            if (!det_s2[`SFS_D_TSD])
              diag_evt[`SFS_DG_TSD] <= 1'b1; // [RULE21]
            det_test_en <= 1'b0;
            det_test_level <= 1'b0;
          end else if (st_cnt == `SFS_SETTLE_CYC) begin
            st <= logic_ok ? `SFS_S_RUN : `SFS_S_HALT; // [RULE19]
          end
        end
        `SFS_S_RUN: begin
          diag_done <= 1'b1; // [RULE17]
          st_cnt <= 8'h00;
        end
        `SFS_S_HALT: begin
          st_cnt <= 8'h00;
        end
        default: st <= `SFS_S_HALT;
      endcase
      // Only the onset of a monitor fail switches, else a standing fail would
      // toggle the oscillator every cycle
      osc_fail_q <= det_s2[`SFS_D_OSC];
      if (osc_bad || (st == `SFS_S_RUN && det_s2[`SFS_D_OSC] && !osc_fail_q)) begin
        diag_evt[`SFS_DG_OSC] <= 1'b1; // [RULE20]
        osc_bad <= 1'b0;
      end
    end
  end

  wire running = (st == `SFS_S_RUN);

  // ==========================================
  // Fault flags and interrupt
  // Events are the synchronised levels (core-buck ones from the qualification filters), voltage ones gated until self-test ends.
  // Temperature ones are gated too: the self-test drives those comparators.
  wire [`SFS_NDET-1:0] volt_evt;
  assign volt_evt[`SFS_VOLT_HI:`SFS_VOLT_LO] =
    {det_s2[`SFS_VOLT_HI:`SFS_D_DC2OC], core_qual, det_s2[`SFS_D_DC1OC:`SFS_VOLT_LO]}
    & {`SFS_VOLT_W{running}}; // [RULE1]
  assign volt_evt[`SFS_D_WRN2:`SFS_D_WRN1] = det_s2[`SFS_D_WRN2:`SFS_D_WRN1] & {2{running}}; // [RULE15]
  assign volt_evt[`SFS_D_TSD] = det_s2[`SFS_D_TSD] & running; // [RULE16]
  assign volt_evt[`SFS_D_OSC] = det_s2[`SFS_D_OSC] & running; // [RULE20]

  wire [`SFS_NFLAG-1:0] evt = {diag_evt, volt_evt};
  reg [`SFS_NFLAG-1:0] flags;
  reg [`SFS_NFLAG-1:0] mask;
  reg [`SFS_NFLAG-1:0] clr;

  function [`SFS_NFLAG-1:0] sfs_place;
    input [1:0] a;
    input [15:0] d;
    begin
      sfs_place = {`SFS_NFLAG{1'b0}};
      if (a == `SFS_A_FLAG0)
        sfs_place[15:0] = d;
      else if (a == `SFS_A_FLAG1)
        sfs_place[`SFS_NFLAG-1:16] = d[`SFS_NFLAG-17:0];
    end
  endfunction

  always @* begin
    clr = reg_wr ? sfs_place(reg_addr, reg_wdata) : {`SFS_NFLAG{1'b0}};
  end

  // Flags are cleared by srst and by host writes to FLAG0/FLAG1, never by system_reset_n.
  always @(posedge ref_clk) begin
    if (srst) begin
      flags <= {`SFS_NFLAG{1'b0}};
      mask <= {`SFS_NFLAG{1'b0}};
    end else if (clk_en) begin
      flags <= (flags & ~clr) | evt; // [RULE24] [RULE2] [RULE14]
      if (reg_wr && reg_addr == `SFS_A_STAT)
        mask[15:0] <= reg_wdata;
      if (reg_wr && reg_addr == `SFS_A_FLAG2)
        mask[`SFS_NFLAG-1:16] <= reg_wdata[`SFS_NFLAG-17:0];
    end
  end

  // Group summaries are derived, so they fall only once every bit is gone.
  wire [1:0] grp_sum = {|flags[`SFS_NFLAG-1:16], |flags[15:0]}; // [RULE23]
  wire diag_err = |flags[`SFS_G_DIAG+`SFS_DIAG_W-1:`SFS_G_DIAG];

  // ==========================================
  // Next values of the pin-level reactions
  // A pre-start test error keeps the pin low even while its flags are masked.
  wire next_fault_irq_n = ~(|(flags & ~mask) | (diag_err & ~running)); // [RULE25] [RULE22]
  // Regulators stay stopped until the self-test hands over.
  wire next_regs_stop = ~running | det_s2[`SFS_D_TSD] | volt_evt[`SFS_D_BAT]; // [RULE5] [RULE16]
  // The core low reset is optional, the deep main-LDO low always resets.
  wire next_system_reset_n = running & ~volt_evt[`SFS_D_L1L2] // [RULE10]
    & ~(core_low_reset_en & volt_evt[`SFS_D_DC2L]); // [RULE4]

  // ==========================================
  // Reactions and outputs
  always @(posedge ref_clk) begin
    if (srst) begin
      fault_irq_n <= 1'b1;
      suspend_out <= 1'b0;
      system_reset_n <= 1'b0;
      regs_stop <= 1'b1;
      buck1_stop <= 1'b0;
      buck1_interval <= 1'b0;
      core_buck_stop <= 1'b0;
      core_buck_interval <= 1'b0;
      protect_mode <= 1'b0;
      osc_select <= 1'b0;
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      fault_irq_n <= next_fault_irq_n; // [RULE25] [RULE22]
      regs_stop <= next_regs_stop; // [RULE5] [RULE16]
      buck1_stop <= volt_evt[`SFS_D_DC1U]; // [RULE6]
      core_buck_stop <= volt_evt[`SFS_D_DC1U] | volt_evt[`SFS_D_DC2U]; // [RULE6] [RULE11]
      buck1_interval <= volt_evt[`SFS_D_DC1L] | volt_evt[`SFS_D_DC1OC]; // [RULE7] [RULE8]
      core_buck_interval <= volt_evt[`SFS_D_DC2L] | volt_evt[`SFS_D_DC2OC]; // [RULE12] [RULE13]
      protect_mode <= volt_evt[`SFS_D_DC2L]; // [RULE12]
      suspend_out <= volt_evt[`SFS_D_L1L1]; // [RULE9]
      system_reset_n <= next_system_reset_n; // [RULE10] [RULE4]
      if (diag_evt[`SFS_DG_OSC])
        osc_select <= ~osc_select; // [RULE20]
      case (reg_addr)
        `SFS_A_FLAG0: reg_rdata <= flags[15:0];
        `SFS_A_FLAG1: reg_rdata <= {4'h0, flags[`SFS_NFLAG-1:16]};
        `SFS_A_FLAG2: reg_rdata <= {4'h0, mask[`SFS_NFLAG-1:16]};
        default: reg_rdata <= {8'h00, st, grp_sum};
      endcase
      if (!reg_rd)
        reg_rdata <= 16'h0000;
    end
  end

endmodule

// ### tb/sfs_host_model.sv
// Host model: counts interrupt assertions seen on the pin.
// Assumes fault_irq_n is a registered active-low level.
`timescale 1ns/1ps
module sfs_host_model (
  input wire ref_clk,
  input wire fault_irq_n,
  output reg [7:0] irq_seen
);
  // ==========================================
  // Edge counter, kept across device resets
  reg irq_q = 1'b1;
  initial irq_seen = 8'h00;
  always @(posedge ref_clk) begin
    irq_q <= fault_irq_n;
    if (irq_q && !fault_irq_n) begin
      irq_seen <= irq_seen + 8'h01;
    end
  end
endmodule

// ### tb/sfs_supervisor_chk.sv
// Checker: reaction timing of the supply fault supervisor at its ports.
// Assumes clk_en is held high; bound to sfs_supervisor at the foot.
`timescale 1ns/1ps
module sfs_supervisor_chk (
  input wire ref_clk,
  input wire srst,
  input wire [22:0] det_in,
  input wire diag_done,
  input wire fault_irq_n,
  input wire suspend_out,
  input wire system_reset_n,
  input wire regs_stop,
  input wire buck1_stop,
  input wire buck1_interval,
  input wire core_buck_stop,
  input wire core_buck_interval,
  input wire protect_mode,
  input wire osc_select
);
  // ==========================================
  // Properties
  // Run length of the core-buck low condition once monitoring is live
  reg [15:0] low_cnt;
  always @(posedge ref_clk) begin
    if (srst || !diag_done || !det_in[5]) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hffff) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_over_held;
    (diag_done && det_in[4]) [*8] ##1 (diag_done && det_in[4]) [*8];
  endsequence
  sequence s_low_held;
    low_cnt == 16'h0974;
  endsequence
  no_early_react_a: assert property (!diag_done |-> !suspend_out && !buck1_interval && !core_buck_interval)
    else $error("reaction before self-test end");
  batt_stop_a: assert property (diag_done && det_in[0] |-> ##[1:8] regs_stop && !fault_irq_n)
    else $error("battery low not handled");
  buck1_over_a: assert property (diag_done && det_in[1] |-> ##[1:8] buck1_stop && core_buck_stop)
    else $error("buck1 over not handled");
  ldo_reset_a: assert property (diag_done && det_in[10] |-> ##[1:8] !system_reset_n)
    else $error("ldo level2 low gave no reset");
  core_over_a: assert property (s_over_held |-> ##[1:10] core_buck_stop && !fault_irq_n)
    else $error("core buck over not handled");
  core_filter_a: assert property (low_cnt > 16'h0008 && low_cnt < 16'h0956 |-> !protect_mode)
    else $error("core buck low not filtered");
  core_low_a: assert property (s_low_held |-> protect_mode && core_buck_interval && !fault_irq_n)
    else $error("core buck low not handled");
  osc_switch_a: assert property (diag_done && $rose(det_in[22]) |-> ##[1:8] $changed(osc_select))
    else $error("oscillator not switched");
endmodule

bind sfs_supervisor sfs_supervisor_chk u_chk (.ref_clk(ref_clk), .srst(srst), .det_in(det_in), .diag_done(diag_done),
  .fault_irq_n(fault_irq_n), .suspend_out(suspend_out), .system_reset_n(system_reset_n), .regs_stop(regs_stop),
  .buck1_stop(buck1_stop), .buck1_interval(buck1_interval), .core_buck_stop(core_buck_stop),
  .core_buck_interval(core_buck_interval), .protect_mode(protect_mode), .osc_select(osc_select));

// ### tb/tb_supply_fault_supervisor.sv
// Testbench: self-test, every detector reaction, masking, failed self-test.
// Assumes comparators follow the test level while det_test_en is high.
`timescale 1ns/1ps
module tb_supply_fault_supervisor;
  // ==========================================
  // Stimulus and bench tasks
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg osc_tick = 1'b0;
  reg [1:0] reg_addr = 2'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [22:0] det_in = 23'h000000;
  reg [22:0] fault = 23'h000000;
  reg brk = 1'b0;
  integer n_fail = 0;
  integer n_compared = 0;
  integer cyc = 0;
  integer k;
  wire [15:0] reg_rdata;
  wire [7:0] irq_seen;
  wire det_test_en, det_test_level, fault_irq_n, suspend_out, system_reset_n, regs_stop, buck1_stop;
  wire buck1_interval, core_buck_stop, core_buck_interval, protect_mode, osc_select, diag_done;
  sfs_supervisor uut (.ref_clk(ref_clk), .srst(srst), .clk_en(1'b1), .det_in(det_in), .osc_tick(osc_tick),
    .core_low_reset_en(1'b1), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .det_test_en(det_test_en), .det_test_level(det_test_level), .fault_irq_n(fault_irq_n),
    .suspend_out(suspend_out), .system_reset_n(system_reset_n), .regs_stop(regs_stop), .buck1_stop(buck1_stop),
    .buck1_interval(buck1_interval), .core_buck_stop(core_buck_stop), .core_buck_interval(core_buck_interval),
    .protect_mode(protect_mode), .osc_select(osc_select), .diag_done(diag_done));
  sfs_host_model host (.ref_clk(ref_clk), .fault_irq_n(fault_irq_n), .irq_seen(irq_seen));
  initial forever #12.5 ref_clk = ~ref_clk;
  // Second oscillator, about 32 ticks per 64-cycle window
  initial forever #25.3 osc_tick = ~osc_tick;
  always @(posedge ref_clk) begin
    det_in <= det_test_en ? (brk ? 23'h000000 : {1'b0, {22{det_test_level}}}) : fault;
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task chk(input [31:0] act, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (act !== exp) begin
        $display("[FAIL] t=%0t got=%h exp=%h", $time, act, exp);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task wr(input [1:0] a, input [15:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [1:0] a, output [15:0] d);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  // Bits: reset low, suspend, all stop, buck1 stop/interval, core stop/interval, protect
  function [7:0] exp_of(input integer b);
    case (b)
      0, 21: exp_of = 8'h20;
      1: exp_of = 8'h14;
      2, 3: exp_of = 8'h08;
      4: exp_of = 8'h04;
      5: exp_of = 8'h83;
      6: exp_of = 8'h02;
      9: exp_of = 8'h40;
      10: exp_of = 8'h80;
      default: exp_of = 8'h00;
    endcase
  endfunction
  task t_diag;
    begin
      #1 chk(diag_done, 1'b0);
      for (k = 0; k < 400 && diag_done !== 1'b1; k = k + 1) @(posedge ref_clk);
      #1 chk(diag_done, 1'b1);
      chk(fault_irq_n, 1'b1);
      chk(system_reset_n, 1'b1);
    end
  endtask
  task t_react(input integer b);
    reg [7:0] e;
    reg [15:0] d;
    reg s;
    begin
      e = exp_of(b);
      s = osc_select;
      @(posedge ref_clk);
      fault <= 23'h000001 << b;
      if (b == 5) begin
        // Still inside the qualification time
        repeat (2300) @(posedge ref_clk);
        #1 chk(fault_irq_n, 1'b1);
      end
      repeat (b == 5 ? 120 : 30) @(posedge ref_clk);
      #1 chk({~system_reset_n, suspend_out, regs_stop, buck1_stop, buck1_interval, core_buck_stop,
        core_buck_interval, protect_mode} & (e == 8'h00 ? 8'hff : e), e);
      chk(fault_irq_n, 1'b0);
      if (b == 22) chk(osc_select, !s);
      @(posedge ref_clk);
      fault <= 23'h000000;
      repeat (8) @(posedge ref_clk);
      rd(b < 16 ? 2'h0 : 2'h1, d);
      chk(d[b % 16], 1'b1);
      wr(2'h0, 16'hffff);
      wr(2'h1, 16'h0fff);
      repeat (4) @(posedge ref_clk);
      #1 chk(fault_irq_n, 1'b1);
    end
  endtask
  task t_mask;
    reg [15:0] d;
    begin
      wr(2'h3, 16'h1000);
      fault <= 23'h001000;
      repeat (30) @(posedge ref_clk);
      #1 chk(fault_irq_n, 1'b1);
      wr(2'h3, 16'h0000);
      fault <= 23'h000000;
      repeat (4) @(posedge ref_clk);
      #1 chk(fault_irq_n, 1'b0);
      rd(2'h3, d);
      chk(d[0], 1'b1);
      wr(2'h0, 16'h1000);
      rd(2'h3, d);
      chk(d[1:0], 2'h0);
    end
  endtask
  task t_fail;
    begin
      @(posedge ref_clk);
      brk <= 1'b1;
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (300) @(posedge ref_clk);
      #1 chk(fault_irq_n, 1'b0);
      repeat (100) @(posedge ref_clk);
      #1 chk(fault_irq_n, 1'b0);
    end
  endtask
  task results;
    begin
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_diag;
    for (k = 0; k < 23; k = k + 1) t_react(k);
    chk(irq_seen >= 8'd22, 1'b1);
    t_mask;
    t_fail;
    results;
  end
endmodule
